//--- common/ctsm_pkg.sv
// Constants for the cache and TCM size override register.
// Operation
// - Bit 31 set adopts the written sizes.
// - Write-enable bit always reads back zero.
// - Decode data tightmem field into banks, size.
// - Decode instr tightmem field, same code table.
// - Decode data cache field into size.
// - Decode instr cache field into size.
// - Reset to implemented sizes, enable bit zero.
// - One shared 32-bit read/write register.
// - Permit clear: only secure privileged may access.
// - Permit set: every mode and world may access.
// - Secure write lock faults secure privileged writes.
// - Decode opcode 0, cache_tcm_size_override, opcode 0 only.
// - Only apparent sizes change, never physical ones.
// - Processor sees sizes through presented outputs.
// - Both tightmems absent hides the DMA engine.
package ctsm_pkg;
    localparam int WREN_BIT = 31;
    localparam int DTM_LSB = 12;
    localparam int ITM_LSB = 8;
    localparam int DC_LSB = 4;
    localparam int IC_LSB = 0;
    localparam int FLD_W = 3;
    localparam logic [2:0] OPC1_SEL = 3'h0;
    localparam logic [3:0] MAJOR_SEL = 4'hF;
    localparam logic [3:0] MINOR_SEL = 4'hE;
    localparam logic [2:0] OPC2_SEL = 3'h0;
    localparam logic [2:0] CODE_ABSENT = 3'h0;
    localparam logic [2:0] CODE_4K = 3'h3;
    localparam logic [2:0] CODE_8K = 3'h4;
    localparam logic [2:0] CODE_16K = 3'h5;
    localparam logic [2:0] CODE_32K = 3'h6;
    localparam logic [2:0] CODE_64K = 3'h7;
    localparam logic [1:0] BANKS_NONE = 2'h0;
    localparam logic [1:0] BANKS_ONE = 2'h1;
    localparam logic [1:0] BANKS_TWO = 2'h2;
    // Sizes are in KB; tightmem sizes are per bank.
    localparam logic [6:0] KB_0 = 7'h00;
    localparam logic [6:0] KB_4 = 7'h04;
    localparam logic [6:0] KB_8 = 7'h08;
    localparam logic [6:0] KB_16 = 7'h10;
    localparam logic [6:0] KB_32 = 7'h20;
    localparam logic [6:0] KB_64 = 7'h40;
endpackage

//--- common/ctsm_dec_if.sv
// Carrier between the register and its size decoder.
`timescale 1ns/1ps
`default_nettype none
interface ctsm_dec_if;
    logic [2:0] data_tightmem_size_field;
    logic [2:0] instr_tightmem_size_field;
    logic [2:0] data_cache_size_field;
    logic [2:0] instr_cache_size_field;
    logic [1:0] dtm_banks;
    logic [6:0] dtm_kb;
    logic dtm_rsvd;
    logic [1:0] itm_banks;
    logic [6:0] itm_kb;
    logic itm_rsvd;
    logic [6:0] dc_kb;
    logic dc_rsvd;
    logic [6:0] ic_kb;
    logic ic_rsvd;
    modport reg_side (
        output data_tightmem_size_field, instr_tightmem_size_field,
        output data_cache_size_field, instr_cache_size_field,
        input dtm_banks, dtm_kb, dtm_rsvd, itm_banks, itm_kb, itm_rsvd,
        input dc_kb, dc_rsvd, ic_kb, ic_rsvd
    );
    modport dec_side (
        input data_tightmem_size_field, instr_tightmem_size_field,
        input data_cache_size_field, instr_cache_size_field,
        output dtm_banks, dtm_kb, dtm_rsvd, itm_banks, itm_kb, itm_rsvd,
        output dc_kb, dc_rsvd, ic_kb, ic_rsvd
    );
endinterface
`default_nettype wire

//--- design/ctsm_size_dec.sv
// Combinational decoder of the four size codes.
`timescale 1ns/1ps
`default_nettype none
module ctsm_size_dec
    import ctsm_pkg::*;
(
    ctsm_dec_if.dec_side d
);
    // Both tightmem fields share one code table.
    function automatic logic [9:0] tm_dec(input logic [2:0] c);
        case (c)
            CODE_ABSENT: tm_dec = {BANKS_NONE, KB_0, 1'b0};
            CODE_4K: tm_dec = {BANKS_ONE, KB_4, 1'b0};
            CODE_8K: tm_dec = {BANKS_TWO, KB_4, 1'b0};
            CODE_16K: tm_dec = {BANKS_TWO, KB_8, 1'b0};
            CODE_32K: tm_dec = {BANKS_TWO, KB_16, 1'b0};
            CODE_64K: tm_dec = {BANKS_TWO, KB_32, 1'b0};
            default: tm_dec = {BANKS_NONE, KB_0, 1'b1};
        endcase
    endfunction
    function automatic logic [7:0] c_dec(input logic [2:0] c);
        case (c)
            CODE_4K: c_dec = {KB_4, 1'b0};
            CODE_8K: c_dec = {KB_8, 1'b0};
            CODE_16K: c_dec = {KB_16, 1'b0};
            CODE_32K: c_dec = {KB_32, 1'b0};
            CODE_64K: c_dec = {KB_64, 1'b0};
            default: c_dec = {KB_0, 1'b1};
        endcase
    endfunction
    always_comb begin
        {d.dtm_banks, d.dtm_kb, d.dtm_rsvd} =
            tm_dec(d.data_tightmem_size_field);
        {d.itm_banks, d.itm_kb, d.itm_rsvd} =
            tm_dec(d.instr_tightmem_size_field);
        {d.dc_kb, d.dc_rsvd} = c_dec(d.data_cache_size_field);
        {d.ic_kb, d.ic_rsvd} = c_dec(d.instr_cache_size_field);
    end
endmodule
`default_nettype wire

//--- design/ctsm_reg.sv
// Cache and tightmem size override register of the control coprocessor.
`timescale 1ns/1ps
`default_nettype none
module ctsm_reg
    import ctsm_pkg::*;
#(
    parameter logic [2:0] IMPL_DTM = 3'h7,
    parameter logic [2:0] IMPL_ITM = 3'h7,
    parameter logic [2:0] IMPL_DC = 3'h7,
    parameter logic [2:0] IMPL_IC = 3'h7
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic srst_i,
    // Coprocessor transfer from the core.
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [2:0] opc1_i,
    input wire logic [3:0] major_reg_selector_i,
    input wire logic [3:0] minor_reg_selector_i,
    input wire logic [2:0] opc2_i,
    input wire logic [31:0] wdata_i,
    input wire logic secure_i,
    input wire logic priv_i,
    input wire logic access_permit_i,
    input wire logic secure_write_lock_in_i,
    // Answer to the core.
    output logic ack_o,
    output logic undef_o,
    output logic [31:0] rdata_o,
    // Apparent configuration presented to the core.
    output logic [1:0] dtm_banks_o,
    output logic [6:0] dtm_kb_o,
    output logic [1:0] itm_banks_o,
    output logic [6:0] itm_kb_o,
    output logic [6:0] dc_kb_o,
    output logic [6:0] ic_kb_o,
    output logic dma_present_o,
    output logic code_rsvd_o
);
    logic [2:0] dtm, itm, dc, ic;
    logic [2:0] next_dtm, next_itm, next_dc, next_ic;
    logic next_ack, next_undef;
    logic [31:0] next_rdata;
    logic [1:0] next_dtm_banks, next_itm_banks;
    logic [6:0] next_dtm_kb, next_itm_kb, next_dc_kb, next_ic_kb;
    logic next_dma, next_rsvd;
    logic hit, allowed, locked, do_write;

    ctsm_dec_if dif ();
    assign dif.data_tightmem_size_field = dtm;
    assign dif.instr_tightmem_size_field = itm;
    assign dif.data_cache_size_field = dc;
    assign dif.instr_cache_size_field = ic;

    ctsm_size_dec u_dec (
        .d (dif.dec_side)
    );

    always_comb begin
        hit = acc_valid_i && opc1_i == OPC1_SEL
            && major_reg_selector_i == MAJOR_SEL
            && minor_reg_selector_i == MINOR_SEL
            && opc2_i == OPC2_SEL;
        // Secure privileged passes except locked writes; others need the permit.
        allowed = (secure_i && priv_i) || access_permit_i;
        locked = acc_write_i && secure_i && priv_i
            && secure_write_lock_in_i;
        do_write = hit && acc_write_i && allowed && !locked
            && wdata_i[WREN_BIT];
        next_dtm = dtm;
        next_itm = itm;
        next_dc = dc;
        next_ic = ic;
        if (do_write) begin
            // Bits 30:15, 11, 7 and 3 are never stored.
            next_dtm = wdata_i[DTM_LSB +: FLD_W];
            next_itm = wdata_i[ITM_LSB +: FLD_W];
            next_dc = wdata_i[DC_LSB +: FLD_W];
            next_ic = wdata_i[IC_LSB +: FLD_W];
        end
        next_ack = hit;
        next_undef = hit && (!allowed || locked);
        next_rdata = 32'h0000_0000;
        if (hit && !acc_write_i && allowed) begin
            // Enable bit and unused bits read as zero.
            next_rdata[DTM_LSB +: FLD_W] = dtm;
            next_rdata[ITM_LSB +: FLD_W] = itm;
            next_rdata[DC_LSB +: FLD_W] = dc;
            next_rdata[IC_LSB +: FLD_W] = ic;
        end
        // Presented sizes only; physical storage is untouched.
        next_dtm_banks = dif.dtm_banks;
        next_dtm_kb = dif.dtm_kb;
        next_itm_banks = dif.itm_banks;
        next_itm_kb = dif.itm_kb;
        next_dc_kb = dif.dc_kb;
        next_ic_kb = dif.ic_kb;
        next_dma = !(dif.dtm_banks == BANKS_NONE
            && dif.itm_banks == BANKS_NONE);
        next_rsvd = dif.dtm_rsvd || dif.itm_rsvd || dif.dc_rsvd
            || dif.ic_rsvd;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dtm <= IMPL_DTM;
            itm <= IMPL_ITM;
            dc <= IMPL_DC;
            ic <= IMPL_IC;
            ack_o <= 1'b0;
            undef_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            dtm_banks_o <= BANKS_NONE;
            dtm_kb_o <= KB_0;
            itm_banks_o <= BANKS_NONE;
            itm_kb_o <= KB_0;
            dc_kb_o <= KB_0;
            ic_kb_o <= KB_0;
            dma_present_o <= 1'b0;
            code_rsvd_o <= 1'b0;
        end else begin
            dtm <= next_dtm;
            itm <= next_itm;
            dc <= next_dc;
            ic <= next_ic;
            ack_o <= next_ack;
            undef_o <= next_undef;
            rdata_o <= next_rdata;
            dtm_banks_o <= next_dtm_banks;
            dtm_kb_o <= next_dtm_kb;
            itm_banks_o <= next_itm_banks;
            itm_kb_o <= next_itm_kb;
            dc_kb_o <= next_dc_kb;
            ic_kb_o <= next_ic_kb;
            dma_present_o <= next_dma;
            code_rsvd_o <= next_rsvd;
        end
    end

    property p_wr_update;
        @(posedge clk_i) disable iff (srst_i)
        do_write |=> dc == $past(wdata_i[DC_LSB +: FLD_W])
            && ic == $past(wdata_i[IC_LSB +: FLD_W])
            && dtm == $past(wdata_i[DTM_LSB +: FLD_W])
            && itm == $past(wdata_i[ITM_LSB +: FLD_W]);
    endproperty
    a_wr_update: assert property (p_wr_update)
        else $error("enabled write did not update sizes");

    property p_no_wren;
        @(posedge clk_i) disable iff (srst_i)
        (hit && acc_write_i && !wdata_i[WREN_BIT]) |=> $stable(dtm)
            && $stable(itm) && $stable(dc) && $stable(ic);
    endproperty
    a_no_wren: assert property (p_no_wren)
        else $error("write without enable changed sizes");

    property p_rd_zero;
        @(posedge clk_i) disable iff (srst_i)
        ##1 (!rdata_o[WREN_BIT] && rdata_o[30:15] == 16'h0000
            && !rdata_o[11] && !rdata_o[7] && !rdata_o[3]);
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("enable or unused bit read nonzero");

    property p_rd_data;
        @(posedge clk_i) disable iff (srst_i)
        (hit && !acc_write_i && allowed) |=>
            rdata_o[DTM_LSB +: FLD_W] == $past(dtm) && ack_o && !undef_o;
    endproperty
    a_rd_data: assert property (p_rd_data)
        else $error("read returned wrong data");

    property p_undef_np;
        @(posedge clk_i) disable iff (srst_i)
        (hit && !access_permit_i && !(secure_i && priv_i)) |=>
            undef_o && rdata_o == 32'h0000_0000;
    endproperty
    a_undef_np: assert property (p_undef_np)
        else $error("unpermitted access not faulted");

    property p_permit;
        @(posedge clk_i) disable iff (srst_i)
        (hit && access_permit_i && !locked) |=> !undef_o;
    endproperty
    a_permit: assert property (p_permit)
        else $error("permitted access faulted");

    property p_lock;
        @(posedge clk_i) disable iff (srst_i)
        (hit && locked) |=> undef_o && $stable(dtm) && $stable(ic);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked secure write not faulted");

    property p_decode;
        @(posedge clk_i) disable iff (srst_i)
        (acc_valid_i && minor_reg_selector_i != MINOR_SEL) |=> !ack_o;
    endproperty
    a_decode: assert property (p_decode)
        else $error("other register selector answered");

    sequence s_both_absent;
        dtm == CODE_ABSENT && itm == CODE_ABSENT;
    endsequence
    property p_dma;
        @(posedge clk_i) disable iff (srst_i)
        s_both_absent ##1 (dtm == $past(dtm) && itm == $past(itm)) |=>
            !dma_present_o;
    endproperty
    a_dma: assert property (p_dma)
        else $error("dma shown with both tightmems absent");

    property p_reset;
        @(posedge clk_i)
        srst_i |=> dc == IMPL_DC && dtm == IMPL_DTM;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not load implemented sizes");

    // The presented outputs lag the stored codes by one edge, and reset
    // clears them, so the decode checks skip the first edge after reset.
    property p_dtm_one;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(dtm) == CODE_4K) |->
            dtm_banks_o == BANKS_ONE && dtm_kb_o == KB_4;
    endproperty
    a_dtm_one: assert property (p_dtm_one)
        else $error("single data tightmem bank not presented");

    property p_itm_two;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(itm) == CODE_64K) |->
            itm_banks_o == BANKS_TWO && itm_kb_o == KB_32;
    endproperty
    a_itm_two: assert property (p_itm_two)
        else $error("largest instr tightmem not presented");

    property p_dc_size;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(dc) == CODE_64K) |->
            dc_kb_o == KB_64;
    endproperty
    a_dc_size: assert property (p_dc_size)
        else $error("largest data cache not presented");

    property p_ic_size;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(ic) == CODE_8K) |->
            ic_kb_o == KB_8;
    endproperty
    a_ic_size: assert property (p_ic_size)
        else $error("instr cache size not presented");

    property p_rsvd;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(dc) < CODE_4K) |-> code_rsvd_o;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved cache code not flagged");

    property p_dc_absent;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(dc) == CODE_ABSENT) |-> dc_kb_o == KB_0;
    endproperty
    a_dc_absent: assert property (p_dc_absent)
        else $error("reserved cache code shown with a size");

    property p_dma_on;
        @(posedge clk_i) disable iff (srst_i)
        (!$past(srst_i) && $past(itm) == CODE_4K) |-> dma_present_o;
    endproperty
    a_dma_on: assert property (p_dma_on)
        else $error("dma hidden while a tightmem is present");

    property p_write_ack;
        @(posedge clk_i) disable iff (srst_i)
        (hit && acc_write_i) |=> ack_o && rdata_o == 32'h0000_0000;
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("write answered with read data");

    property p_no_hit;
        @(posedge clk_i) disable iff (srst_i)
        !hit |=> !ack_o && !undef_o;
    endproperty
    a_no_hit: assert property (p_no_hit)
        else $error("answer without a matching transfer");

    property p_undef_ack;
        @(posedge clk_i) disable iff (srst_i)
        undef_o |-> ack_o;
    endproperty
    a_undef_ack: assert property (p_undef_ack)
        else $error("fault raised without an answer");

    // A write shows up in the registers first and on the outputs one
    // edge later, which the core must allow for before trusting them.
    sequence s_wr_dc16;
        do_write && wdata_i[DC_LSB +: FLD_W] == CODE_16K;
    endsequence
    sequence s_shows_dc16;
        ##1 dc_kb_o == KB_16;
    endsequence
    property p_wr_present;
        @(posedge clk_i) disable iff (srst_i)
        s_wr_dc16 |=> s_shows_dc16;
    endproperty
    a_wr_present: assert property (p_wr_present)
        else $error("written cache size not presented");
endmodule
`default_nettype wire

//--- tb/ctsm_core_model.sv
// Core-side model that issues coprocessor transfers to the register.
`timescale 1ns/1ps
`default_nettype none
module ctsm_core_model
    import ctsm_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Transfer towards the register.
    output logic acc_valid_o,
    output logic acc_write_o,
    output logic [2:0] opc1_o,
    output logic [3:0] major_o,
    output logic [3:0] minor_o,
    output logic [2:0] opc2_o,
    output logic [31:0] wdata_o,
    output logic secure_o,
    output logic priv_o,
    output logic permit_o,
    output logic lock_o
);
    initial begin
        {acc_valid_o, acc_write_o, secure_o, priv_o, permit_o, lock_o} = '0;
        {opc1_o, major_o, minor_o, opc2_o, wdata_o} = '1;
    end
    // Called at a falling edge; bad picks one selector to spoil.
    task automatic xfer(logic wr, sec, prv, perm, lck, int bad,
                        logic [31:0] d);
        acc_valid_o = 1'b1;
        acc_write_o = wr;
        {secure_o, priv_o, permit_o, lock_o} = {sec, prv, perm, lck};
        opc1_o = OPC1_SEL ^ 3'(bad == 1);
        major_o = MAJOR_SEL ^ 4'(bad == 2);
        minor_o = MINOR_SEL ^ 4'(bad == 3);
        opc2_o = OPC2_SEL ^ 3'(bad == 4);
        wdata_o = d & 32'h80007777;
        @(posedge clk_i);
        @(negedge clk_i);
        // Released lines show inverted junk so stale values never match.
        acc_valid_o = 1'b0;
        wdata_o = ~wdata_o;
        {opc1_o, major_o, minor_o, opc2_o} =
            ~{opc1_o, major_o, minor_o, opc2_o};
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the cache and tightmem size override register.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    wire logic acc_valid_i, acc_write_i, secure_i, priv_i, permit, lock;
    wire logic [2:0] opc1_i, opc2_i;
    wire logic [3:0] major, minor;
    wire logic [31:0] wdata_i;
    logic [31:0] rdata_o;
    logic ack_o, undef_o, dma_present_o, code_rsvd_o;
    logic [1:0] dtm_banks_o, itm_banks_o;
    logic [6:0] dtm_kb_o, itm_kb_o, dc_kb_o, ic_kb_o;
    int fail_count = 0;
    int cmp_count = 0;
    int fld [4];
    logic [31:0] r = 32'h352A;

    always #5 clk_i = ~clk_i;

    ctsm_core_model core_u (.clk_i(clk_i), .acc_valid_o(acc_valid_i),
        .acc_write_o(acc_write_i), .opc1_o(opc1_i), .major_o(major),
        .minor_o(minor), .opc2_o(opc2_i), .wdata_o(wdata_i),
        .secure_o(secure_i), .priv_o(priv_i), .permit_o(permit),
        .lock_o(lock));
    ctsm_reg #(.IMPL_DTM(3'h7), .IMPL_ITM(3'h3), .IMPL_DC(3'h5),
        .IMPL_IC(3'h4)) dut_u (.clk_i(clk_i), .srst_i(srst_i),
        .acc_valid_i(acc_valid_i), .acc_write_i(acc_write_i),
        .opc1_i(opc1_i), .major_reg_selector_i(major),
        .minor_reg_selector_i(minor), .opc2_i(opc2_i), .wdata_i(wdata_i),
        .secure_i(secure_i), .priv_i(priv_i), .access_permit_i(permit),
        .secure_write_lock_in_i(lock), .ack_o(ack_o), .undef_o(undef_o),
        .rdata_o(rdata_o), .dtm_banks_o(dtm_banks_o), .dtm_kb_o(dtm_kb_o),
        .itm_banks_o(itm_banks_o), .itm_kb_o(itm_kb_o), .dc_kb_o(dc_kb_o),
        .ic_kb_o(ic_kb_o), .dma_present_o(dma_present_o),
        .code_rsvd_o(code_rsvd_o));

    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int tkb(int c);
        return c == 3 ? 4 : (c >= 4 ? 4 << (c - 4) : 0);
    endfunction
    function automatic int tbk(int c);
        return c == 3 ? 1 : (c >= 4 ? 2 : 0);
    endfunction
    function automatic int ckb(int c);
        return c >= 3 ? 4 << (c - 3) : 0;
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp_ans(logic ack, logic flt, logic [31:0] rd);
        chk(ack_o, ack, "ack");
        chk(undef_o, flt, "undef");
        chk(rdata_o, rd, "rdata");
    endtask
    task automatic cmp_size();
        logic rs;
        rs = fld[0] inside {1, 2} || fld[1] inside {1, 2} || fld[2] < 3;
        rs = rs || fld[3] < 3;
        chk(code_rsvd_o, rs, "reserved flag");
        chk(dtm_kb_o, tkb(fld[0]), "dtm kb");
        chk(itm_kb_o, tkb(fld[1]), "itm kb");
        chk(dc_kb_o, ckb(fld[2]), "dc kb");
        chk(ic_kb_o, ckb(fld[3]), "ic kb");
        if (!rs) begin
            chk(dtm_banks_o, tbk(fld[0]), "dtm banks");
            chk(itm_banks_o, tbk(fld[1]), "itm banks");
            chk(dma_present_o, fld[0] != 0 || fld[1] != 0, "dma");
        end
    endtask

    // Called at a falling edge; leaves at a falling edge.
    task automatic do_xfer(logic wr, sec, prv, perm, lck, int bad,
                           logic [31:0] d);
        logic flt;
        logic [31:0] exp;
        flt = !(sec && prv || perm) || (wr && sec && prv && lck);
        exp = {17'h0, fld[0][2:0], 1'b0, fld[1][2:0], 1'b0, fld[2][2:0],
               1'b0, fld[3][2:0]};
        if (wr || flt) begin
            exp = 32'h0;
        end
        core_u.xfer(wr, sec, prv, perm, lck, bad, d);
        if (bad != 0) begin
            cmp_ans(1'b0, 1'b0, 32'h0);
        end else begin
            cmp_ans(1'b1, flt, exp);
        end
        if (bad == 0 && wr && !flt && d[31]) begin
            fld = '{d[14:12], d[10:8], d[6:4], d[2:0]};
        end
        @(negedge clk_i);
        cmp_size();
    endtask

    task automatic do_reset();
        srst_i = 1'b1;
        repeat (5) @(negedge clk_i);
        srst_i = 1'b0;
        fld = '{7, 3, 5, 4};
        repeat (2) @(negedge clk_i);
        cmp_size();
        $display("test reset done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        $display("unexpected %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        do_reset();
        do_xfer(0, 1, 1, 0, 0, 0, 32'h0);
        for (int c = 0; c < 8; c++) begin
            do_xfer(1, 1, 1, 0, 0, 0, {1'b1, 16'h0, c[2:0], 1'b0, c[2:0],
                    1'b0, c[2:0], 1'b0, c[2:0]});
            do_xfer(0, 1, 1, 0, 0, 0, 32'h0);
        end
        do_xfer(1, 1, 1, 0, 0, 0, 32'h80000037);
        do_xfer(1, 1, 1, 0, 0, 0, 32'h00003456);
        $display("test codes done");
        for (int i = 0; i < 120; i++) begin
            r = lfsr_next(r);
            do_xfer(r[4], r[0], r[1], r[2], r[3],
                    (r[18] & r[19]) ? int'(r[21:20]) + 1 : 0,
                    {r[5], 16'h0, r[8:6], 1'b0, r[11:9], 1'b0, r[14:12],
                     1'b0, r[17:15]});
        end
        $display("test random access done");
        do_reset();
        wrap_up();
    end
endmodule
`default_nettype wire
